// ### rtl/fpe_top.sv
// Protection registers and erase-verify-section sequencer of a flash
// controller.
// Assumes all inputs come from logic on ref_clk, and that the flash
// array answers each read request with exactly one response pulse.
`timescale 1ns/10ps
`default_nettype none

module fpe_top
    import fpe_pkg::*;
(
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // Operating mode
    input  wire logic         modeNormal,
    input  wire logic         modeSpecial,
    // Program flash protection write port
    input  wire logic         pfProtWr,
    input  wire logic [2:0]   pfProtWrScen,
    // EEPROM protection write port
    input  wire logic         eeProtWr,
    input  wire fpe_ee_prot_t eeProtWrVal,
    // Command words and launch
    input  wire fpe_cmd_t     cmdWords,
    input  wire logic [2:0]   cmd_word_index,
    input  wire logic         cmdLaunch,
    input  wire logic         accErrClr,
    // Flash array read port
    output logic              rdReq,
    output logic [23:0]       rdAddr,
    input  wire fpe_rd_rsp_t  rdRsp,
    // Protection state
    output logic [2:0]        pflash_protect_reg,
    output fpe_ee_prot_t      eeprom_protect_reg,
    output logic [EE_SIZE_W-1:0] eeEffectiveSize,
    // Status flags
    output logic              cmd_complete_flag,
    output logic              access_error_flag,
    output logic              protect_violation_flag,
    output logic              memctl_status_hi,
    output logic              memctl_status_lo
);

    // ********************************************************
    // Sequencer state
    // ********************************************************
    typedef enum logic [2:0] {
        ST_CFG_RD,
        ST_CFG_WAIT,
        ST_IDLE,
        ST_VFY_RD,
        ST_VFY_WAIT
    } fpe_state_t;

    fpe_state_t   state_ff;
    fpe_state_t   nxt_state;
    logic [23:0]  addr_ff;
    logic [23:0]  nxt_addr;
    logic [15:0]  left_ff;
    logic [15:0]  nxt_left;
    logic         cmd_complete_flag_ff;
    logic         nxt_cmd_complete_flag;
    logic         access_error_flag_ff;
    logic         nxt_access_error_flag;
    logic         statHi_ff;
    logic         nxt_statHi;
    logic         statLo_ff;
    logic         nxt_statLo;

    // ********************************************************
    // Protection state
    // ********************************************************
    logic [2:0]   pfScen_ff;
    logic [2:0]   nxt_pfScen;
    fpe_ee_prot_t eeProt_ff;
    fpe_ee_prot_t nxt_eeProt;
    logic [7:0]   cfgByte;

    // ********************************************************
    // Launch checks
    // ********************************************************
    logic [23:0]  startAddr;
    logic [24:0]  sectEnd;
    logic         badIndex;
    logic         badMode;
    logic         badCode;
    logic         badAddr;
    logic         badAlign;
    logic         badCross;
    logic         launchErr;
    logic         launchOk;
    logic         phraseBlank;

    // Launch is only honoured while no command runs.
    assign launchOk  = cmdLaunch && cmd_complete_flag_ff && (state_ff == ST_IDLE);
    assign startAddr = {cmdWords.word0[7:0], cmdWords.word1};
    // One extra bit keeps the end address from wrapping at the top.
    // The count is turned into bytes and sized before the add, so even
    // the largest count keeps all of its upper bits.
    assign sectEnd   = {1'b0, startAddr}
                     + 25'({cmdWords.word2, 3'h0});

    // Each check feeds the access error on its own.
    assign badIndex  = cmd_word_index != CMD_INDEX_LAST;
    assign badMode   = !(modeNormal || modeSpecial);
    assign badCode   = cmdWords.word0[15:8] != CMD_ERASE_VERIFY_SECT;
    assign badAddr   = startAddr < PFLASH_BASE;
    assign badAlign  = startAddr[2:0] != PHRASE_ALIGN_BITS;
    assign badCross  = sectEnd > PFLASH_LIMIT;
    assign launchErr = badIndex || badMode || badCode || badAddr
                     || badAlign || badCross;

    // A phrase is blank only when every bit still reads as erased.
    assign phraseBlank = rdRsp.data == ERASED_PHRASE;
    assign cfgByte     = rdRsp.data[CFG_BYTE_LANE*8 +: 8];

    // ********************************************************
    // Sequencer next state
    // ********************************************************
    // Configuration load runs first so that protection is valid before
    // software can start any command.
    always_comb begin
        nxt_state  = state_ff;
        nxt_addr   = addr_ff;
        nxt_left   = left_ff;
        nxt_cmd_complete_flag   = cmd_complete_flag_ff;
        nxt_statHi = statHi_ff;
        nxt_statLo = statLo_ff;
        nxt_access_error_flag = access_error_flag_ff;
        rdReq      = 1'b0;
        // A clear from software loses against a fresh error.
        if (accErrClr) begin
            nxt_access_error_flag = 1'b0;
        end
        case (state_ff)
            ST_CFG_RD: begin
                // The request already stands during reset, so the fetch
                // is taken on the first edge after release.
                rdReq     = 1'b1;
                nxt_state = ST_CFG_WAIT;
            end
            ST_CFG_WAIT: begin
                if (rdRsp.valid) begin
                    nxt_cmd_complete_flag  = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (launchOk) begin
                    nxt_statHi = 1'b0;
                    nxt_statLo = 1'b0;
                    if (launchErr) begin
                        // Refused command: flag it and stay complete.
                        nxt_access_error_flag = 1'b1;
                    end else if (cmdWords.word2 == 16'h0000) begin
                        nxt_cmd_complete_flag = 1'b1;
                    end else begin
                        nxt_cmd_complete_flag  = 1'b0;
                        nxt_addr  = startAddr;
                        nxt_left  = cmdWords.word2;
                        nxt_state = ST_VFY_RD;
                    end
                end
            end
            ST_VFY_RD: begin
                rdReq     = 1'b1;
                nxt_state = ST_VFY_WAIT;
            end
            ST_VFY_WAIT: begin
                if (rdRsp.valid) begin
                    // Verify runs to the last phrase even after a failure,
                    // so every read error in the section is reported.
                    if (!phraseBlank) begin
                        nxt_statHi = 1'b1;
                        nxt_statLo = 1'b1;
                    end
                    if (rdRsp.errAny || rdRsp.errFatal) begin
                        nxt_statHi = 1'b1;
                    end
                    if (rdRsp.errFatal) begin
                        nxt_statLo = 1'b1;
                    end
                    nxt_left = left_ff - 16'h0001;
                    nxt_addr = addr_ff + PHRASE_BYTES[23:0];
                    if (left_ff == 16'h0001) begin
                        nxt_cmd_complete_flag  = 1'b1;
                        nxt_state = ST_IDLE;
                    end else begin
                        nxt_state = ST_VFY_RD;
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_cmd_complete_flag  = 1'b1;
            end
        endcase
    end

    // Sequencer registers; complete flag stays low until the
    // configuration byte has been fetched.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff  <= ST_CFG_RD;
            addr_ff   <= CFG_PHRASE_ADDR;
            left_ff   <= 16'h0000;
            cmd_complete_flag_ff   <= 1'b0;
            access_error_flag_ff <= 1'b0;
            statHi_ff <= 1'b0;
            statLo_ff <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            addr_ff   <= nxt_addr;
            left_ff   <= nxt_left;
            cmd_complete_flag_ff   <= nxt_cmd_complete_flag;
            access_error_flag_ff <= nxt_access_error_flag;
            statHi_ff <= nxt_statHi;
            statLo_ff <= nxt_statLo;
        end
    end

    // ********************************************************
    // Protection next values
    // ********************************************************
    // Protection can only grow in normal mode; special mode may also
    // remove it, which is what lets a bench unlock the part.
    always_comb begin
        nxt_pfScen = pfScen_ff;
        nxt_eeProt = eeProt_ff;
        if (pfProtWr) begin
            if (!modeNormal || PF_ALLOWED[pfScen_ff][pfProtWrScen]) begin
                nxt_pfScen = pfProtWrScen;
            end
        end
        if (state_ff == ST_CFG_WAIT && rdRsp.valid) begin
            nxt_eeProt.open = cfgByte[CFG_OPEN_BIT];
            nxt_eeProt.size = cfgByte[EE_SIZE_W-1:0];
        end else if (eeProtWr) begin
            if (modeSpecial || !modeNormal) begin
                nxt_eeProt = eeProtWrVal;
            end else begin
                if (eeProtWrVal.size > eeProt_ff.size) begin
                    nxt_eeProt.size = eeProtWrVal.size;
                end
                if (!eeProtWrVal.open) begin
                    nxt_eeProt.open = 1'b0;
                end
            end
        end
    end

    // Protection registers.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pfScen_ff      <= PF_SCEN_RESET;
            eeProt_ff.open <= EE_OPEN_RESET;
            eeProt_ff.size <= EE_SIZE_RESET;
        end else begin
            pfScen_ff <= nxt_pfScen;
            eeProt_ff <= nxt_eeProt;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    // The read address comes straight from a register, so it is steady
    // for as long as a request is outstanding.
    assign rdAddr                 = addr_ff;
    assign pflash_protect_reg     = pfScen_ff;
    assign eeprom_protect_reg     = eeProt_ff;
    // Zero size means no sector protected at all.
    assign eeEffectiveSize        = eeProt_ff.open ? '0
                                  : eeProt_ff.size;
    assign cmd_complete_flag      = cmd_complete_flag_ff;
    assign access_error_flag      = access_error_flag_ff;
    // This command never raises a protection violation.
    assign protect_violation_flag = 1'b0;
    assign memctl_status_hi       = statHi_ff;
    assign memctl_status_lo       = statLo_ff;

endmodule

`default_nettype wire

// ### include/fpe_pkg.sv
// Shared constants and carrier types for the flash protection and
// erase-verify sequencer.
// Assumes a single 50 MHz clock and a flash array reached by a
// one-request, one-answer read port.
package fpe_pkg;

    // ********************************************************
    // Command words and phrase layout
    // ********************************************************
    localparam logic [7:0]  CMD_ERASE_VERIFY_SECT = 8'h03;
    localparam logic [2:0]  CMD_INDEX_LAST        = 3'h2;
    localparam logic [2:0]  PHRASE_ALIGN_BITS     = 3'h0;
    localparam logic [24:0] PHRASE_BYTES          = 25'h0000008;
    localparam logic [63:0] ERASED_PHRASE         = 64'hFFFFFFFFFFFFFFFF;

    // ********************************************************
    // Program flash address window
    // ********************************************************
    localparam logic [23:0] PFLASH_BASE  = 24'hFE0000;
    localparam logic [24:0] PFLASH_LIMIT = 25'h1000000;

    // ********************************************************
    // Protection layout and reset values
    // ********************************************************
    localparam logic [23:0] CFG_PROT_ADDR      = 24'hFFFE0D;
    localparam int          CFG_BYTE_LANE      = 5;
    localparam int          CFG_OPEN_BIT       = 7;
    localparam int          EE_SIZE_W          = 5;
    localparam logic [2:0]  PF_SCEN_RESET      = 3'h7;
    localparam logic        EE_OPEN_RESET      = 1'h1;
    localparam logic [4:0]  EE_SIZE_RESET      = 5'h00;
    localparam logic [23:0] CFG_PHRASE_ADDR    = 24'hFFFE08;

    // One row per current scenario: bit n set means scenario n may follow.
    localparam logic [7:0] PF_ALLOWED [8] = '{
        8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF
    };

    // ********************************************************
    // Carrier types
    // ********************************************************
    typedef struct packed {
        logic [15:0] word2;
        logic [15:0] word1;
        logic [15:0] word0;
    } fpe_cmd_t;

    typedef struct packed {
        logic        valid;
        logic [63:0] data;
        logic        errAny;
        logic        errFatal;
    } fpe_rd_rsp_t;

    typedef struct packed {
        logic                 open;
        logic [EE_SIZE_W-1:0] size;
    } fpe_ee_prot_t;

endpackage

// ### dv/fpe_top_assertions.sv
// Concurrent checks on the ports of the flash protection sequencer.
// Assumes fpe_pkg is compiled first; bound to every fpe_top instance.
`timescale 1ns/10ps
`default_nettype none

module fpe_top_assertions
    import fpe_pkg::*;
(
    // Clock, reset and requests
    input wire logic                 ref_clk,
    input wire logic                 rst,
    input wire logic                 modeNormal,
    input wire logic                 pfProtWr,
    input wire logic                 eeProtWr,
    input wire logic                 cmdLaunch,
    input wire logic                 accErrClr,
    // Observed state and flags
    input wire logic                 rdReq,
    input wire logic [2:0]           pflash_protect_reg,
    input wire fpe_ee_prot_t         eeprom_protect_reg,
    input wire logic [EE_SIZE_W-1:0] eeEffectiveSize,
    input wire logic                 cmd_complete_flag,
    input wire logic                 access_error_flag,
    input wire logic                 memctl_status_hi,
    input wire logic                 memctl_status_lo
);
    // ********************************************************
    // Protection and sequencer properties
    // ********************************************************
    default clocking cbk @(posedge ref_clk); endclocking
    default disable iff (rst);

    // A normal-mode write may only land on a scenario allowed from the old.
    AST_PF_LEGAL: assert property (pfProtWr && modeNormal |=>
        PF_ALLOWED[$past(pflash_protect_reg)][pflash_protect_reg])
        else $error("program scenario moved illegally");
    AST_PF_HOLD: assert property (!pfProtWr |=>
        $stable(pflash_protect_reg))
        else $error("program scenario changed without a write");
    AST_EE_SIZE: assert property (eeProtWr && modeNormal |=>
        eeprom_protect_reg.size >= $past(eeprom_protect_reg.size))
        else $error("protected size shrank in normal mode");
    AST_EE_OPEN: assert property (eeProtWr && modeNormal &&
        !eeprom_protect_reg.open |=> !eeprom_protect_reg.open)
        else $error("open bit reopened in normal mode");
    // The open bit masks the size, so no sector reads as protected.
    AST_EE_EFF: assert property (eeEffectiveSize ==
        (eeprom_protect_reg.open ? '0 : eeprom_protect_reg.size))
        else $error("effective size ignores the open bit");
    AST_LAUNCH_CLR: assert property ($fell(cmd_complete_flag) |->
        $past(cmdLaunch))
        else $error("complete flag fell without a launch");
    AST_BUSY_RD: assert property (rdReq |-> !cmd_complete_flag)
        else $error("read issued while complete");
    AST_ACC_CAUSE: assert property ($rose(access_error_flag) |->
        $past(cmdLaunch))
        else $error("access error rose without a launch");
    AST_ACC_KEEP: assert property (access_error_flag &&
        !accErrClr |=> access_error_flag)
        else $error("access error dropped without a clear");
    // Status must not drift while idle, or software reads a stale verdict.
    AST_STAT_KEEP: assert property (cmd_complete_flag &&
        !cmdLaunch |=> $stable(memctl_status_hi) && $stable(memctl_status_lo))
        else $error("status bits changed while idle");

    COV_FAIL: cover property ($rose(cmd_complete_flag) && memctl_status_lo);
    COV_ACC: cover property ($rose(access_error_flag));
    COV_PF: cover property (pfProtWr && modeNormal);
endmodule

bind fpe_top fpe_top_assertions u_fpe_chk (.ref_clk, .rst, .modeNormal,
    .pfProtWr, .eeProtWr, .cmdLaunch, .accErrClr, .rdReq,
    .pflash_protect_reg, .eeprom_protect_reg, .eeEffectiveSize,
    .cmd_complete_flag, .access_error_flag, .memctl_status_hi,
    .memctl_status_lo);
`default_nettype wire

// ### dv/fpe_top_tb.sv
// Self-checking bench for fpe_top: protection writes and erase verify.
// Assumes fpe_pkg and the bound checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none

module fpe_top_tb
    import fpe_pkg::*;
;
    logic         ref_clk, rst, modeNormal, modeSpecial, pfProtWr;
    logic         eeProtWr, cmdLaunch, accErrClr, rdReq, cFlag, aFlag;
    logic         pViol, sHi, sLo;
    logic [2:0]   pfScen, cmdIdx, pfReg;
    logic [23:0]  rdAddr;
    logic [4:0]   effSize;
    fpe_ee_prot_t eeVal, eeReg;
    fpe_cmd_t     cmdWords;
    fpe_rd_rsp_t  rdRsp;
    // Command code and mode used by run; changed for the refused code and mode cases and the accepted spec case.
    logic [7:0]   runCode = 8'h03;
    logic [1:0]   runMode = 2'b10;
    int           fails = 0, n_tests = 0, cyc = 0;
    // Row n lists the scenarios reachable from scenario n.
    localparam logic [7:0] ALW [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08,
                                       8'h18, 8'h3C, 8'h5A, 8'hFF};

    fpe_top DUT (.ref_clk(ref_clk), .rst(rst), .modeNormal(modeNormal),
        .modeSpecial(modeSpecial), .pfProtWr(pfProtWr),
        .pfProtWrScen(pfScen), .eeProtWr(eeProtWr), .eeProtWrVal(eeVal),
        .cmdWords(cmdWords), .cmd_word_index(cmdIdx),
        .cmdLaunch(cmdLaunch), .accErrClr(accErrClr), .rdReq(rdReq),
        .rdAddr(rdAddr), .rdRsp(rdRsp), .pflash_protect_reg(pfReg),
        .eeprom_protect_reg(eeReg), .eeEffectiveSize(effSize),
        .cmd_complete_flag(cFlag), .access_error_flag(aFlag),
        .protect_violation_flag(pViol), .memctl_status_hi(sHi),
        .memctl_status_lo(sLo));

    // ********************************************************
    // Clock, watchdog and access tasks
    // ********************************************************
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // A hung handshake ends the run as a failure.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            results();
        end
    end

    task automatic tick(int n = 1);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic chk(string nm, logic [23:0] exp, logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask

    // Waits for a read request, checks its address, answers a cycle later.
    task automatic ans(logic [23:0] a, logic [63:0] d, logic ea, logic ef);
        for (int i = 0; i < 50 && rdReq !== 1'b1; i++) tick();
        chk("rdReq", 24'h1, 24'(rdReq));
        chk("rdAddr", a, rdAddr);
        tick();
        rdRsp = '{1'b1, d, ea, ef};
        tick();
        rdRsp.valid = 1'b0;
    endtask

    task automatic pfw(logic nrm, logic [2:0] s);
        modeNormal = nrm;
        modeSpecial = !nrm;
        pfScen = s;
        pfProtWr = 1'b1;
        tick();
        pfProtWr = 1'b0;
        tick();
    endtask

    task automatic eew(logic nrm, logic [5:0] v, logic [5:0] e);
        modeNormal = nrm;
        modeSpecial = !nrm;
        eeVal = v;
        eeProtWr = 1'b1;
        tick();
        eeProtWr = 1'b0;
        tick();
        chk("eeProt", 24'(e), 24'(eeReg));
        chk("eeEff", e[5] ? 24'h0 : 24'(e[4:0]), 24'(effSize));
    endtask

    // Launches one erase verify; exp holds {access, status hi, status lo}.
    task automatic run(string nm, logic [23:0] a, logic [15:0] n,
                       logic [2:0] ix, int bad, logic ea, logic ef,
                       logic [2:0] exp);
        {modeNormal, modeSpecial} = runMode;
        cmdWords = '{n, a[15:0], {runCode, a[23:16]}};
        cmdIdx = ix;
        cmdLaunch = 1'b1;
        tick();
        cmdLaunch = 1'b0;
        chk("busy", 24'(exp[2]), 24'(cFlag));
        if (!exp[2])
            for (int k = 0; k < n; k++)
                ans(a + 24'(8 * k), (k == bad) ? 64'h0 : '1,
                    ea && k == 0, ef && k == 0);
        for (int k = 0; k < 50 && cFlag !== 1'b1; k++) tick();
        chk("done", 24'h1, 24'(cFlag));
        chk("flags", 24'(exp), 24'({pViol, aFlag, sHi, sLo}));
        accErrClr = 1'b1;
        tick();
        accErrClr = 1'b0;
        chk("accClr", 24'h0, 24'(aFlag));
        $display("test %s done", nm);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ********************************************************
    // Test sequence
    // ********************************************************
    initial begin
        {rst, modeNormal, modeSpecial, pfProtWr, eeProtWr} = 5'h18;
        {cmdLaunch, accErrClr, pfScen, cmdIdx} = 8'h00;
        eeVal = '0;
        cmdWords = '0;
        rdRsp = '0;
        tick(6);
        rst = 1'b0;
        // Only lane 5 carries the protection byte; other lanes are decoys.
        ans(24'hFFFE08, 64'hFFFF_04FF_FFFF_FFFF, 1'b0, 1'b0);
        tick(2);
        chk("cfgProt", 24'h04, 24'(eeReg));
        chk("cfgDone", 24'h1, 24'(cFlag));
        $display("test reset done");
        for (int f = 0; f < 8; f++) begin
            for (int t = 0; t < 8; t++) begin
                pfw(1'b0, 3'(f));
                pfw(1'b1, 3'(t));
                chk("pfScen", ALW[f][t] ? 24'(t) : 24'(f), 24'(pfReg));
            end
        end
        $display("test pflash done");
        eew(1'b1, 6'h03, 6'h04);
        eew(1'b1, 6'h04, 6'h04);
        eew(1'b1, 6'h09, 6'h09);
        eew(1'b1, 6'h29, 6'h09);
        eew(1'b0, 6'h22, 6'h22);
        eew(1'b1, 6'h01, 6'h02);
        eew(1'b0, 6'h01, 6'h01);
        $display("test eeprom done");
        run("ok", 24'hFE0100, 16'h3, 3'h2, -1, 0, 0, 3'b000);
        run("last", 24'hFFFFF8, 16'h1, 3'h2, -1, 0, 0, 3'b000);
        run("index", 24'hFE0100, 16'h1, 3'h1, -1, 0, 0, 3'b100);
        run("range", 24'hFD0000, 16'h1, 3'h2, -1, 0, 0, 3'b100);
        run("align", 24'hFE0104, 16'h1, 3'h2, -1, 0, 0, 3'b100);
        run("cross", 24'hFFFFF8, 16'h2, 3'h2, -1, 0, 0, 3'b100);
        run("blank", 24'hFE0200, 16'h2, 3'h2, 1, 0, 0, 3'b011);
        run("rdErr", 24'hFE0300, 16'h2, 3'h2, -1, 1, 0, 3'b010);
        run("fatal", 24'hFE0300, 16'h1, 3'h2, -1, 1, 1, 3'b011);
        runCode = 8'h04;
        run("code", 24'hFE0100, 16'h1, 3'h2, -1, 0, 0, 3'b100);
        runCode = 8'h03;
        runMode = 2'b01;
        run("spec", 24'hFE0400, 16'h1, 3'h2, -1, 0, 0, 3'b000);
        runMode = 2'b00;
        run("mode", 24'hFE0100, 16'h1, 3'h2, -1, 0, 0, 3'b100);
        results();
    end
endmodule
`default_nettype wire
